/* logic/tsmc_pkg.sv */
// constants for the temperature monitor management and control block
package tsmc_pkg;
  // two-wire addressing
  localparam logic [6:0] GCALL_ADDR      = 7'h00;
  localparam logic [7:0] GCALL_RESET     = 8'h06;
  localparam logic [6:0] OWN_ADDR        = 7'h4c;
  // register pointers
  localparam logic [7:0] PTR_LOCAL_TEMP  = 8'h00;
  localparam logic [7:0] PTR_REMOTE_TEMP = 8'h01;
  localparam logic [7:0] PTR_STATUS      = 8'h02;
  localparam logic [7:0] PTR_CONFIG_RD   = 8'h03;
  localparam logic [7:0] PTR_CONFIG_WR   = 8'h09;
  localparam logic [7:0] PTR_MAKER_ID    = 8'hfe;
  localparam logic [7:0] PTR_PART_ID     = 8'hff;
  // identity values, arbitrary
  localparam logic [7:0] MAKER_ID_VAL    = 8'ha5;
  localparam logic [7:0] PART_ID_VAL     = 8'h3c;
  // field positions
  localparam int CFG_MASK_BIT            = 7;
  localparam int CFG_PDOWN_BIT           = 6;
  localparam int STAT_BUSY_BIT           = 7;
  localparam int STAT_OPEN_BIT           = 2;
  // reset values
  localparam logic [7:0] CONFIG_RST      = 8'h00;
  localparam logic [7:0] TEMP_RST        = 8'h00;
  // conversion time
  localparam int CONV_TIME_US            = 100;
  localparam int CLK_MHZ                 = 25;
  localparam int CONV_CYCLES             = CONV_TIME_US * CLK_MHZ;
endpackage

/* logic/tsmc_sync.sv */
// two flip-flop synchroniser for one bit
`timescale 1ns/1ps
module tsmc_sync (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // async level in, synced out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q; // first stage, read only by second
  // two stages, reset high (idle bus level)
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

/* logic/tsmc_conv.sv */
// conversion sequencer with fault and supply handling
`timescale 1ns/1ps
module tsmc_conv (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       soft_rst,
  // control
  input  wire logic       pdown,
  input  wire logic       supply_ok,
  input  wire logic       fault,
  input  wire logic [7:0] sample,
  // results
  output logic [7:0]      temp_q,
  output logic            busy_q,
  output logic            open_evt
);
  logic [15:0] cnt_q;      // cycles left in conversion
  logic        fault_q;    // fault seen this conversion
  wire         done = busy_q && (cnt_q == 16'h0000);
  wire         start = !busy_q && !pdown && supply_ok;
  // sequencer
  always_ff @(posedge clk) begin
    if (!rst_n || soft_rst) begin
      busy_q  <= 1'b0;
      cnt_q   <= 16'h0000;
      fault_q <= 1'b0;
      temp_q  <= tsmc_pkg::TEMP_RST;
    end else if (start) begin
      busy_q  <= 1'b1;
      cnt_q   <= 16'(tsmc_pkg::CONV_CYCLES - 1);
      fault_q <= 1'b0;
    end else if (busy_q) begin
      if (!supply_ok) begin
        busy_q <= 1'b0;
      end else if (done) begin
        busy_q <= 1'b0;
        if (!fault_q && !fault) begin
          temp_q <= sample;
        end
      end else begin
        cnt_q   <= cnt_q - 16'h0001;
        fault_q <= fault_q | fault;
      end
    end
  end
  // fault report at end of conversion
  assign open_evt = done && supply_ok && (fault_q || fault);
endmodule

/* logic/tsmc_top.sv */
// temperature monitor management: two-wire target, registers, alarms
// Operation
// - power-down after current conversion completes
// - convert continuously while power-down clear
// - fault keeps old result, sets open
// - fault drives alert low unless masked
// - no conversion while supply invalid
// - acknowledge general call, take second byte
// - reset code restores registers, aborts, releases
// - other general-call bytes change nothing
// - pointer fe reads maker identity
// - pointer ff reads part identity
// - identity registers ignore writes
// - mask bit holds alert inactive
`timescale 1ns/1ps
module tsmc_top (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // two-wire bus pins
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  // analog front-end status
  input  wire logic       SUPPLY_OK,
  input  wire logic       REMOTE_FAULT,
  input  wire logic       OVER_LIMIT,
  input  wire logic [7:0] REMOTE_SAMPLE,
  // alarms, open drain low active
  output logic            ALERT_N_OE,
  output logic            CRITICAL_THERMAL_ALARM_OUT_N_OE,
  // power state
  output logic            POWERED_DOWN
);
  // state machine of the target
  // idle: waits for a start condition
  // addr: shifts in the address byte
  // aack: drives the address acknowledge
  // wbyt: shifts in pointer, data or code byte
  // wack: drives the write acknowledge
  // rbyt: shifts out the selected register
  // rack: listens for the master acknowledge
  // states advance on synced bus clock falls
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WBYT = 3'b011,
    ST_WACK = 3'b100,
    ST_RBYT = 3'b101,
    ST_RACK = 3'b110
  } tsmc_state_t;

  logic        scl_s, sda_s;        // synced pins
  logic        scl_p_q, sda_p_q;    // previous samples
  tsmc_state_t st_q, st_d;          // bus state
  logic [7:0]  sh_q;                // shift register
  logic [3:0]  bit_q;               // bit counter
  logic        gcall_q;             // general call in progress
  logic        first_q;             // next write byte is pointer
  logic [7:0]  ptr_q;               // register pointer
  logic [7:0]  cfg_q;               // configuration register
  logic        open_q;              // open-fault status
  logic        alert_q;             // alert latch
  logic        sda_oe_q;            // bus drive
  logic        soft_rst_q;          // general-call reset pulse
  logic [7:0]  temp;                // conversion result
  logic        busy;                // conversion running
  logic        open_evt;            // fault at end of conversion

  // bus pins are asynchronous to the system clock
  // two stages each before any logic reads them
  // both reset high, the idle level of the bus,
  // so no false edge is seen after reset
  // adds two to three cycles of latency per edge
  // the bus clock must stay low several cycles
  // pin synchronisers
  tsmc_sync u_scl (.CLK(CLK), .RST_N(RST_N), .async_i(SCL_I), .sync_o(scl_s));
  tsmc_sync u_sda (.CLK(CLK), .RST_N(RST_N), .async_i(SDA_I), .sync_o(sda_s));

  // conversion engine
  tsmc_conv u_conv (
    .clk      (CLK),
    .rst_n    (RST_N),
    .soft_rst (soft_rst_q),
    .pdown    (cfg_q[tsmc_pkg::CFG_PDOWN_BIT]),
    .supply_ok(SUPPLY_OK),
    .fault    (REMOTE_FAULT),
    .sample   (REMOTE_SAMPLE),
    .temp_q   (temp),
    .busy_q   (busy),
    .open_evt (open_evt)
  );

  // engine stops itself once power-down is set
  // and restarts as soon as the bit clears
  // supply loss aborts without touching the result
  // soft reset aborts and clears the result

  // edges found by comparing synced pin with history
  // start and stop need the bus clock high twice,
  // so a data change near a clock edge is not taken
  // bus events
  wire scl_rise = scl_s && !scl_p_q;
  wire scl_fall = !scl_s && scl_p_q;
  wire start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;
  wire stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;
  wire byte_end = (bit_q == 4'h8);
  wire [7:0] sh_n = {sh_q[6:0], sda_s};
  // address match: own or general call write
  // general call accepted
  wire gc_hit   = (sh_q[7:1] == tsmc_pkg::GCALL_ADDR) && !sh_q[0];
  wire own_hit  = (sh_q[7:1] == tsmc_pkg::OWN_ADDR);
  wire addr_hit = own_hit || gc_hit;
  // status byte
  wire [7:0] status = {busy, 4'h0, open_q, 2'b00};

  // both temperature pointers show the one result
  // identity values are constants with no store
  // unmapped pointers read as zero
  // read multiplexer
  logic [7:0] rd_data;
  always_comb begin
    unique case (ptr_q)
      tsmc_pkg::PTR_LOCAL_TEMP:  rd_data = temp;
      tsmc_pkg::PTR_REMOTE_TEMP: rd_data = temp;
      tsmc_pkg::PTR_STATUS:      rd_data = status;
      tsmc_pkg::PTR_CONFIG_RD:   rd_data = cfg_q;
      tsmc_pkg::PTR_MAKER_ID:    rd_data = tsmc_pkg::MAKER_ID_VAL;
      tsmc_pkg::PTR_PART_ID:     rd_data = tsmc_pkg::PART_ID_VAL;
      default:                   rd_data = 8'h00;
    endcase
  end

  // states change on bus clock falls, or at a start, a stop or a master nack,
  // so the data line is moved while the clock is low
  // a read address that is a general call is not read
  // next bus state on scl falling edges
  always_comb begin
    st_d = st_q;
    if (scl_fall) begin
      unique case (st_q)
        ST_IDLE: st_d = ST_IDLE;
        ST_ADDR: st_d = byte_end ? (addr_hit ? ST_AACK : ST_IDLE) : ST_ADDR;
        ST_AACK: st_d = sh_q[0] && !gc_hit ? ST_RBYT : ST_WBYT;
        ST_WBYT: st_d = byte_end ? ST_WACK : ST_WBYT;
        ST_WACK: st_d = ST_WBYT;
        ST_RBYT: st_d = byte_end ? ST_RACK : ST_RBYT;
        ST_RACK: st_d = ST_RBYT;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // pin history
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // bus sequencer, bit counter, shift data
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q  <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
    end else if (start_c) begin
      st_q  <= ST_ADDR;
      bit_q <= 4'h0;
    end else if (stop_c) begin
      st_q  <= ST_IDLE;
    end else begin
      st_q <= st_d;
      if (scl_rise && (st_q == ST_ADDR || st_q == ST_WBYT)) begin
        sh_q  <= sh_n;
        bit_q <= bit_q + 4'h1;
      end else if (scl_rise && st_q == ST_RBYT) begin
        bit_q <= bit_q + 4'h1;
      end else if (scl_fall && (st_q == ST_AACK || st_q == ST_WACK || st_q == ST_RACK)) begin
        bit_q <= 4'h0;
        if (st_d == ST_RBYT) begin
          sh_q <= rd_data;
        end
      end else if (scl_rise && st_q == ST_RACK && sda_s) begin
        // master nack ends reading
        st_q <= ST_IDLE;
      end
    end
  end

  // open drain: enable high pulls the line low
  // first read bit comes straight from the multiplexer,
  // later bits from the loaded shift register
  // start or stop always releases the line
  // sda drive: ack and read data, changed on scl low
  always_ff @(posedge CLK) begin
    if (!RST_N || start_c || stop_c) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (st_d)
        ST_AACK: sda_oe_q <= 1'b1;
        ST_WACK: sda_oe_q <= 1'b1;
        ST_RBYT: sda_oe_q <= (st_q == ST_RBYT) ? !sh_q[6 - bit_q[2:0] + 3'h1] : !rd_data[7];
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  // first byte after the address is the pointer,
  // the rest go to the pointed register
  // only the configuration write pointer stores
  // general call code bytes never reach registers
  // soft reset is one cycle wide and clears itself
  // register writes and general call
  always_ff @(posedge CLK) begin
    if (!RST_N || soft_rst_q) begin
      ptr_q      <= 8'h00;
      cfg_q      <= tsmc_pkg::CONFIG_RST;
      gcall_q    <= 1'b0;
      first_q    <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= 1'b0;
      if (scl_fall && st_q == ST_ADDR && byte_end) begin
        gcall_q <= gc_hit;
        first_q <= 1'b1;
      end else if (scl_fall && st_q == ST_WBYT && byte_end) begin
        first_q <= 1'b0;
        if (gcall_q) begin
          soft_rst_q <= (sh_q == tsmc_pkg::GCALL_RESET);
        end else if (first_q) begin
          ptr_q <= sh_q;
        end else if (ptr_q == tsmc_pkg::PTR_CONFIG_WR) begin
          cfg_q <= sh_q;
        end
      end
    end
  end

  // a fault in the clearing cycle keeps the flag set
  // open-fault flag, cleared by status read, set wins
  always_ff @(posedge CLK) begin
    if (!RST_N || soft_rst_q) begin
      open_q <= 1'b0;
    end else if (open_evt) begin
      open_q <= 1'b1;
    end else if (scl_fall && st_q == ST_RACK && ptr_q == tsmc_pkg::PTR_STATUS) begin
      open_q <= 1'b0;
    end
  end

  // alert drops when the flag is read and cause is gone
  // alert latch follows open flag and limits
  always_ff @(posedge CLK) begin
    if (!RST_N || soft_rst_q) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= open_q || open_evt || OVER_LIMIT;
    end
  end

  // data output is held low; only the enable moves
  // mask gates the early alert only, never critical
  // critical alarm held off in the reset cycle
  // power-down shown once the engine has gone idle
  // outputs
  assign SDA_O  = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign ALERT_N_OE = alert_q && !cfg_q[tsmc_pkg::CFG_MASK_BIT];
  assign CRITICAL_THERMAL_ALARM_OUT_N_OE = alert_q && OVER_LIMIT && !soft_rst_q;
  assign POWERED_DOWN = cfg_q[tsmc_pkg::CFG_PDOWN_BIT] && !busy;
endmodule

/* dv/tsmc_checker.sv */
// pin-level assertions for the monitor management block
`timescale 1ns/1ps
module tsmc_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus pins
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  // front end and outputs
  input wire logic REMOTE_FAULT,
  input wire logic OVER_LIMIT,
  input wire logic ALERT_N_OE,
  input wire logic CRITICAL_THERMAL_ALARM_OUT_N_OE,
  input wire logic POWERED_DOWN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] scl_idle_q;  // cycles since the bus clock moved
  logic       scl_prev_q;  // bus clock one cycle ago
  // count quiet bus-clock cycles
  always_ff @(posedge CLK) begin
    scl_prev_q <= SCL_I;
    if (!RST_N || SCL_I != scl_prev_q) begin
      scl_idle_q <= 8'h00;
    end else if (scl_idle_q != 8'hff) begin
      scl_idle_q <= scl_idle_q + 8'h01;
    end
  end
  // pulled-low bit stands at least five system clock cycles
  sequence oe_held;
    SDA_OE [*5];
  endsequence
  // clock held high, as outside frames
  sequence scl_quiet;
    SCL_I [*8];
  endsequence
  sda_o_low_a: assert property (SDA_O == 1'b0)
    else $error("data output not held low");
  reset_quiet_a: assert property (disable iff (1'b0) !RST_N |=> !SDA_OE && !ALERT_N_OE
    && !CRITICAL_THERMAL_ALARM_OUT_N_OE && !POWERED_DOWN)
    else $error("output active after reset edge");
  oe_scl_low_a: assert property ($changed(SDA_OE) |-> !$past(SCL_I))
    else $error("data enable moved with clock high");
  oe_stands_a: assert property ($rose(SDA_OE) |-> oe_held)
    else $error("data enable dropped early");
  idle_release_a: assert property (scl_quiet |-> !SDA_OE)
    else $error("data held low on idle bus");
  alert_cause_a: assert property ($rose(ALERT_N_OE) |-> REMOTE_FAULT || OVER_LIMIT)
    else $error("alert without cause");
  crit_cause_a: assert property ($rose(CRITICAL_THERMAL_ALARM_OUT_N_OE) |-> OVER_LIMIT)
    else $error("critical alarm without cause");
  wake_bus_a: assert property ($fell(POWERED_DOWN) |-> scl_idle_q < 8'hc8)
    else $error("power-down left without bus traffic");
endmodule

/* dv/tsmc_master.sv */
// two-wire bus master model, clock stands high between frames
`timescale 1ns/1ps
module tsmc_master (
  // clock
  input wire logic CLK,
  // resolved data line
  input wire logic sda,
  // driven pins
  output logic     scl,
  output logic     sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // wait n falling edges
  task automatic tk(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // one bit: data set with clock low, line sampled late in high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    tk(2);
    scl = 1'b1;
    tk(3);
    r = sda;
    tk(1);
    scl = 1'b0;
    tk(2);
  endtask
  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  // stop, then bus free
  task automatic stop();
    sda_low = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b0;
    tk(8);
  endtask
  // byte out msb first, ack is line low in ninth bit
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // byte in msb first, then ack or nack
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the monitor management block
`timescale 1ns/1ps
module testbench;
  typedef struct {logic w; logic [7:0] p; logic [7:0] d; logic [7:0] e;} tsmc_row_t;
  localparam logic [7:0] RT = tsmc_pkg::PTR_REMOTE_TEMP;
  localparam logic [7:0] CW = tsmc_pkg::PTR_CONFIG_WR;
  localparam logic [7:0] MK = tsmc_pkg::MAKER_ID_VAL;
  localparam logic [7:0] PI = tsmc_pkg::PART_ID_VAL;
  logic clk = 1'b0, rst_n = 1'b0, supply_ok = 1'b1, fault = 1'b0, ack, over_limit = 1'b0;
  logic [7:0] sample = 8'h2a, rd;
  logic scl, sda_low, sda_o, sda_oe, alert_oe, crit_oe, pdown;
  int err_total = 0, checked = 0;
  wire sda = !(sda_low || (sda_oe && !sda_o));
  // identity rows, writes must not stick; 7f is unmapped
  tsmc_row_t rows [5] = '{'{0, 8'hfe, 0, MK}, '{0, 8'hff, 0, PI}, '{1, 8'hfe, 8'h5a, MK},
    '{1, 8'hff, 8'h5a, PI}, '{1, 8'h7f, 8'h5a, 8'h00}};
  always #20 clk = !clk;
  tsmc_master i_tsmc_master (.CLK(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  tsmc_top i_tsmc_top (.CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SUPPLY_OK(supply_ok), .REMOTE_FAULT(fault), .OVER_LIMIT(over_limit),
    .REMOTE_SAMPLE(sample), .ALERT_N_OE(alert_oe),
    .CRITICAL_THERMAL_ALARM_OUT_N_OE(crit_oe), .POWERED_DOWN(pdown));
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic s);
    cmp8(n, {7'h00, e}, {7'h00, s});
  endtask
  // register write and read over the bus
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_tsmc_master.start();
    i_tsmc_master.put({tsmc_pkg::OWN_ADDR, 1'b0}, ack);
    i_tsmc_master.put(p, ack);
    i_tsmc_master.put(d, ack);
    i_tsmc_master.stop();
  endtask
  task automatic rdr(input logic [7:0] p);
    i_tsmc_master.start();
    i_tsmc_master.put({tsmc_pkg::OWN_ADDR, 1'b0}, ack);
    i_tsmc_master.put(p, ack);
    i_tsmc_master.start();
    i_tsmc_master.put({tsmc_pkg::OWN_ADDR, 1'b1}, ack);
    i_tsmc_master.get(1'b1, rd);
    i_tsmc_master.stop();
  endtask
  // general call and one code byte
  task automatic gcall(input logic [7:0] c);
    i_tsmc_master.start();
    i_tsmc_master.put({tsmc_pkg::GCALL_ADDR, 1'b0}, ack);
    cmp1("general call ack", 1'b1, ack);
    i_tsmc_master.put(c, ack);
    i_tsmc_master.stop();
  endtask
  // long enough for a whole conversion
  task automatic conv();
    repeat (2 * tsmc_pkg::CONV_CYCLES + 100) @(negedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    cmp1("pdown in reset", 1'b0, pdown);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].p, rows[i].d);
      rdr(rows[i].p);
      cmp8("identity", rows[i].e, rd);
    end
    $display("identity test done");
    conv();
    rdr(RT);
    cmp8("first result", 8'h2a, rd);
    wr(CW, 8'h40);
    for (int w = 0; w < tsmc_pkg::CONV_CYCLES + 200 && !pdown; w++) @(negedge clk);
    cmp1("powered down", 1'b1, pdown);
    sample = 8'h5b;
    conv();
    rdr(RT);
    cmp8("held while down", 8'h2a, rd);
    wr(CW, 8'h00);
    cmp1("awake", 1'b0, pdown);
    conv();
    rdr(RT);
    cmp8("resumed", 8'h5b, rd);
    $display("power-down test done");
    supply_ok = 1'b0;
    sample = 8'h77;
    conv();
    rdr(RT);
    cmp8("held no supply", 8'h5b, rd);
    supply_ok = 1'b1;
    fault = 1'b1;
    conv();
    rdr(RT);
    cmp8("held on fault", 8'h5b, rd);
    cmp1("alert on fault", 1'b1, alert_oe);
    gcall(8'h05);
    cmp1("alert kept", 1'b1, alert_oe);
    wr(CW, 8'h80);
    cmp1("alert masked", 1'b0, alert_oe);
    over_limit = 1'b1;
    repeat (4) @(negedge clk);
    cmp1("critical on limit", 1'b1, crit_oe);
    cmp1("alert masked on limit", 1'b0, alert_oe);
    over_limit = 1'b0;
    repeat (4) @(negedge clk);
    gcall(8'h07);
    rdr(tsmc_pkg::PTR_CONFIG_RD);
    cmp8("config kept", 8'h80, rd);
    fault = 1'b0;
    gcall(tsmc_pkg::GCALL_RESET);
    rdr(RT);
    cmp8("temp after reset", tsmc_pkg::TEMP_RST, rd);
    rdr(tsmc_pkg::PTR_CONFIG_RD);
    cmp8("config after reset", tsmc_pkg::CONFIG_RST, rd);
    cmp1("alert released", 1'b0, alert_oe);
    cmp1("critical released", 1'b0, crit_oe);
    $display("general call test done");
    fault = 1'b1;
    conv();
    rdr(tsmc_pkg::PTR_STATUS);
    cmp1("open flag", 1'b1, rd[tsmc_pkg::STAT_OPEN_BIT]);
    fault = 1'b0;
    $display("fault flag test done");
    summarize();
  end
  // watchdog
  initial begin
    repeat (80000) @(negedge clk);
    err_total++;
    summarize();
  end
endmodule
bind tsmc_top tsmc_checker i_tsmc_checker (.CLK(CLK), .RST_N(RST_N), .SCL_I(SCL_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .REMOTE_FAULT(REMOTE_FAULT), .OVER_LIMIT(OVER_LIMIT),
  .ALERT_N_OE(ALERT_N_OE), .POWERED_DOWN(POWERED_DOWN),
  .CRITICAL_THERMAL_ALARM_OUT_N_OE(CRITICAL_THERMAL_ALARM_OUT_N_OE));
